// ===== core/dcc_pkg.sv
package dcc_pkg;

  // ==========================================================================
  // Channel select encodings
  // ==========================================================================
  localparam logic [2:0] NEG_PIN0 = 3'h0;
  localparam logic [2:0] NEG_PIN3 = 3'h3;
  localparam logic [2:0] NEG_FVR = 3'h6;
  localparam logic [2:0] NEG_GND = 3'h7;
  localparam logic [2:0] POS_PIN0 = 3'h0;
  localparam logic [2:0] POS_PIN1 = 3'h1;
  localparam logic [2:0] POS_DAC = 3'h5;
  localparam logic [2:0] POS_FVR = 3'h6;
  localparam logic [2:0] POS_GND = 3'h7;

  // ==========================================================================
  // Control register A layout and reset value
  // ==========================================================================
  localparam int CTLA_ON_BIT = 7;
  localparam int CTLA_RES_BIT = 6;
  localparam int CTLA_INV_BIT = 4;
  localparam int CTLA_HYS_BIT = 1;
  localparam int CTLA_SYNC_BIT = 0;
  localparam logic [7:0] CTLA_RESET = 8'h00;
  localparam int NUM_CMP = 2;

  // One-hot source routing for one comparator input.
  typedef struct packed {
    logic [3:0] pin;
    logic dac;
    logic fvr;
    logic gnd;
  } dcc_route_t;

  // Per-comparator configuration.
  typedef struct packed {
    logic comparator_on;
    logic output_invert;
    logic input_deadband_enable;
    logic sync_enable;
    logic rise_edge_irq_enable;
    logic fall_edge_irq_enable;
    logic [2:0] positive_channel_select;
    logic [2:0] negative_channel_select;
  } dcc_cfg_t;

endpackage

// ===== core/dcc_channel.sv
`timescale 1ns/1ps
// ============================================================================
// One comparator: gating, polarity, latching, sync and edge detection
// ============================================================================
module dcc_channel (
  input wire logic ref_clk,
  input wire logic reset,
  input wire dcc_pkg::dcc_cfg_t cfg,
  input wire logic raw_compare,
  input wire logic tmr1_clk_pre,
  input wire logic flag_clear,
  output logic result_q,
  output logic pin_out,
  output logic timer_gate,
  output logic flag_q,
  output dcc_pkg::dcc_route_t pos_route,
  output dcc_pkg::dcc_route_t neg_route,
  output logic deadband_on,
  output logic analog_power
);

  logic raw_s1_q;
  logic raw_s2_q;
  logic tclk_s1_q;
  logic tclk_s2_q;
  logic tclk_d1_q;
  logic sync_q;
  logic prev_q;
  logic polar;
  logic tclk_fall;
  logic rise_hit;
  logic fall_hit;
  logic async_out;

  function automatic dcc_pkg::dcc_route_t neg_decode(input logic [2:0] sel, input logic on);
    dcc_pkg::dcc_route_t r;
    r = '0;
    if (on) begin
      if (sel <= dcc_pkg::NEG_PIN3) r.pin[sel[1:0]] = 1'b1;
      else if (sel == dcc_pkg::NEG_FVR) r.fvr = 1'b1;
      else if (sel == dcc_pkg::NEG_GND) r.gnd = 1'b1;
    end
    return r;
  endfunction

  function automatic dcc_pkg::dcc_route_t pos_decode(input logic [2:0] sel, input logic on);
    dcc_pkg::dcc_route_t r;
    r = '0;
    if (on) begin
      if (sel == dcc_pkg::POS_PIN0 || sel == dcc_pkg::POS_PIN1) r.pin[sel[1:0]] = 1'b1;
      else if (sel == dcc_pkg::POS_DAC) r.dac = 1'b1;
      else if (sel == dcc_pkg::POS_FVR) r.fvr = 1'b1;
      else if (sel == dcc_pkg::POS_GND) r.gnd = 1'b1;
    end
    return r;
  endfunction

  // R1 - enable gates comparator
  assign analog_power = cfg.comparator_on;
  // R7 - hysteresis control
  assign deadband_on = cfg.comparator_on & cfg.input_deadband_enable;
  // R2 R18 R20 - negative routing
  assign neg_route = neg_decode(cfg.negative_channel_select, cfg.comparator_on);
  // R2 R17 R21 - positive routing
  assign pos_route = pos_decode(cfg.positive_channel_select, cfg.comparator_on);
  // R3 R16 - polarity, off reads invert
  assign polar = (cfg.comparator_on & raw_s2_q) ^ cfg.output_invert;
  // R11 R12 - sample on falling edge
  assign tclk_fall = tclk_d1_q & ~tclk_s2_q;
  // R6 - unregistered pin copy
  assign async_out = polar;
  // R10 - sync only via Timer1 clock
  assign pin_out = cfg.sync_enable ? sync_q : async_out;
  // R8 - gate source to timers
  assign timer_gate = pin_out;
  // R23 - edge detectors
  assign rise_hit = result_q & ~prev_q;
  assign fall_hit = ~result_q & prev_q;

  // Analog result and Timer1 clock are asynchronous, so both get two stages.
  always_ff @(posedge ref_clk) begin
    raw_s1_q <= raw_compare;
    raw_s2_q <= raw_s1_q;
    tclk_s1_q <= tmr1_clk_pre;
    tclk_s2_q <= tclk_s1_q;
    tclk_d1_q <= tclk_s2_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_q <= 1'b0;
      prev_q <= 1'b0;
      sync_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      // R6 - latch each cycle
      result_q <= polar;
      prev_q <= result_q;
      if (tclk_fall) sync_q <= polar;
      // R13 R15 - set wins over clear
      if ((rise_hit & cfg.rise_edge_irq_enable) | (fall_hit & cfg.fall_edge_irq_enable))
        flag_q <= 1'b1;
      else if (flag_clear)
        flag_q <= 1'b0;
    end
  end

endmodule // dcc_channel

// ===== core/dcc_top.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Comparator runs only while enabled; off means lowest current.
// R2 - Disabled comparator disconnects every input path.
// R3 - Output high when positive input exceeds negative; invert complements.
// R4 - Result readable as per-comparator bit and shared two-bit mirror.
// R5 - Software maps pin source and clears direction to output result.
// R6 - Internal result latched each cycle; pin copies unregistered unless synced. dcc_top registers pin_result every ref_clk cycle.
// R7 - Hysteresis control adds or removes input separation voltage.
// R8 - Results offered as gate sources to odd timers.
// R9 - Software should enable sync when gating a timer.
// R10 - Synchronization uses only the Timer1 clock.
// R11 - Synced output registered on falling edge of prescaled Timer1 clock.
// R12 - Timer1 counts on rising edge; sample on falling edge.
// R13 - Separate rise and fall detectors set flag when enabled.
// R14 - Software sets all enables for interrupt to reach processor.
// R15 - Software clears flag; simultaneous edge keeps it set.
// R16 - Toggling invert or enable while off can set the flag.
// R17 - Positive select routes pin, DAC or fixed reference.
// R18 - Negative select routes pin, fixed reference or ground.
// R19 - Software sets analog select and direction before pin use.
// R20 - Negative codes: pins 0-3, two unused, reference, ground.
// R21 - Positive codes: pins 0-1, three unused, DAC, reference, ground.
// R22 - Control A: enable, result, invert, hysteresis, sync bits.
// R23 - Edge fires one cycle when result differs from previous.
module dcc_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire dcc_pkg::dcc_cfg_t cfg_1,
  input wire dcc_pkg::dcc_cfg_t cfg_2,
  input wire logic raw_compare_1,
  input wire logic raw_compare_2,
  input wire logic tmr1_clk_pre,
  input wire logic flag_clear_1,
  input wire logic flag_clear_2,
  output logic [7:0] comparator_control_a_1,
  output logic [7:0] comparator_control_a_2,
  output logic [1:0] shared_result_mirror,
  output logic [1:0] comparator_irq_flag,
  output logic [1:0] pin_result,
  output logic [1:0] timer_gate,
  output dcc_pkg::dcc_route_t pos_route_1,
  output dcc_pkg::dcc_route_t neg_route_1,
  output dcc_pkg::dcc_route_t pos_route_2,
  output dcc_pkg::dcc_route_t neg_route_2,
  output logic [1:0] deadband_on,
  output logic [1:0] analog_power
);

  // ==========================================================================
  // Channels
  // ==========================================================================
  logic [1:0] res;
  logic [1:0] flg;
  logic [1:0] pin_c;
  logic [1:0] gate_c;
  logic [1:0] db_c;
  logic [1:0] pw_c;
  dcc_pkg::dcc_route_t pr1;
  dcc_pkg::dcc_route_t nr1;
  dcc_pkg::dcc_route_t pr2;
  dcc_pkg::dcc_route_t nr2;
  logic [7:0] ctla_1;
  logic [7:0] ctla_2;

  dcc_channel u_ch1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg_1),
    .raw_compare(raw_compare_1),
    .tmr1_clk_pre(tmr1_clk_pre),
    .flag_clear(flag_clear_1),
    .result_q(res[0]),
    .pin_out(pin_c[0]),
    .timer_gate(gate_c[0]),
    .flag_q(flg[0]),
    .pos_route(pr1),
    .neg_route(nr1),
    .deadband_on(db_c[0]),
    .analog_power(pw_c[0])
  );

  dcc_channel u_ch2 (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg_2),
    .raw_compare(raw_compare_2),
    .tmr1_clk_pre(tmr1_clk_pre),
    .flag_clear(flag_clear_2),
    .result_q(res[1]),
    .pin_out(pin_c[1]),
    .timer_gate(gate_c[1]),
    .flag_q(flg[1]),
    .pos_route(pr2),
    .neg_route(nr2),
    .deadband_on(db_c[1]),
    .analog_power(pw_c[1])
  );

  // ==========================================================================
  // Status view
  // ==========================================================================
  function automatic logic [7:0] ctla_view(input dcc_pkg::dcc_cfg_t c, input logic r);
    logic [7:0] v;
    v = dcc_pkg::CTLA_RESET;
    v[dcc_pkg::CTLA_ON_BIT] = c.comparator_on;
    v[dcc_pkg::CTLA_RES_BIT] = r;
    v[dcc_pkg::CTLA_INV_BIT] = c.output_invert;
    v[dcc_pkg::CTLA_HYS_BIT] = c.input_deadband_enable;
    v[dcc_pkg::CTLA_SYNC_BIT] = c.sync_enable;
    return v;
  endfunction

  // R22 - control A layout
  assign ctla_1 = ctla_view(cfg_1, res[0]);
  assign ctla_2 = ctla_view(cfg_2, res[1]);

  // Outputs are registered, which adds one cycle to every path but keeps
  // the pin copies glitch free toward the timer gates.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      comparator_control_a_1 <= dcc_pkg::CTLA_RESET;
      comparator_control_a_2 <= dcc_pkg::CTLA_RESET;
      shared_result_mirror <= 2'h0;
      comparator_irq_flag <= 2'h0;
      pin_result <= 2'h0;
      timer_gate <= 2'h0;
      pos_route_1 <= '0;
      neg_route_1 <= '0;
      pos_route_2 <= '0;
      neg_route_2 <= '0;
      deadband_on <= 2'h0;
      analog_power <= 2'h0;
    end else begin
      comparator_control_a_1 <= ctla_1;
      comparator_control_a_2 <= ctla_2;
      // R4 - shared mirror
      shared_result_mirror <= res;
      // R13 - flags out
      comparator_irq_flag <= flg;
      // R6 R11 - pin copies
      pin_result <= pin_c;
      // R8 - timer gate sources
      timer_gate <= gate_c;
      // R2 - gated routing
      pos_route_1 <= pr1;
      neg_route_1 <= nr1;
      pos_route_2 <= pr2;
      neg_route_2 <= nr2;
      // R7 R1 - analog controls
      deadband_on <= db_c;
      analog_power <= pw_c;
    end
  end

endmodule // dcc_top

// ===== dv/dcc_far_model.sv
`timescale 1ns/1ps
// ==========
// Analog sources and Timer1 clock of the far side
// ==========
module dcc_far_model (
  input wire logic ref_clk,
  input wire logic [7:0] pos_level,
  input wire logic [7:0] neg_level,
  input wire logic tmr_run,
  output logic raw_compare,
  output logic tmr1_clk_pre
);
  logic [1:0] div_q = 2'h0;
  logic clk_q = 1'b1;
  // analog-only inputs
  // An ideal front end: offsets and response time are not modelled.
  assign raw_compare = pos_level > neg_level;
  assign tmr1_clk_pre = clk_q;
  // prescaled clock
  // It stops only while high, so no late falling edge follows a stop.
  always @(posedge ref_clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3 && (tmr_run || !clk_q)) begin
      clk_q <= !clk_q;
    end
  end
endmodule // dcc_far_model

// ===== dv/dcc_top_sva.sv
`timescale 1ns/1ps
// ==========
// Checker on comparator one, whose logic comparator two shares
// ==========
module dcc_top_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire dcc_pkg::dcc_cfg_t cfg_1,
  input wire logic raw_compare_1,
  input wire logic tmr1_clk_pre,
  input wire logic [7:0] comparator_control_a_1,
  input wire logic [1:0] shared_result_mirror,
  input wire logic [1:0] comparator_irq_flag,
  input wire logic [1:0] pin_result,
  input wire logic [1:0] timer_gate,
  input wire dcc_pkg::dcc_route_t pos_route_1,
  input wire logic [1:0] analog_power
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_POWER: assert property (cfg_1.comparator_on [*3] |-> analog_power[0])
    else $error("power low while enabled");
  AST_OFF: assert property (!cfg_1.comparator_on [*3] |-> !{analog_power[0], pos_route_1})
    else $error("disabled comparator connected");
  AST_MIRROR: assert property (shared_result_mirror[0] == comparator_control_a_1[6])
    else $error("mirror differs from status bit");
  AST_POL: assert property ((cfg_1.comparator_on && !cfg_1.sync_enable
    && $stable({cfg_1.output_invert, raw_compare_1})) [*6]
    |-> {comparator_control_a_1[6], pin_result[0]} == {2{raw_compare_1 ^ cfg_1.output_invert}})
    else $error("result polarity wrong");
  AST_DISABLED: assert property ((!cfg_1.comparator_on && $stable(cfg_1.output_invert)) [*6]
    |-> comparator_control_a_1[6] == cfg_1.output_invert)
    else $error("disabled result not invert bit");
  AST_GATE: assert property (timer_gate == pin_result)
    else $error("gate differs from pin");
  AST_SYNC: assert property ((cfg_1.sync_enable && tmr1_clk_pre) [*8] |-> $stable(pin_result[0]))
    else $error("synced pin moved without timer fall");
  AST_RISE: assert property ($rose(shared_result_mirror[0]) && cfg_1.rise_edge_irq_enable
    |-> ##[1:3] comparator_irq_flag[0])
    else $error("rise did not set flag");
endmodule // dcc_top_chk

bind dcc_top dcc_top_chk u_chk (.ref_clk, .reset, .cfg_1, .raw_compare_1, .tmr1_clk_pre,
  .comparator_control_a_1, .shared_result_mirror, .comparator_irq_flag, .pin_result,
  .timer_gate, .pos_route_1, .analog_power);

// ===== dv/tb_top.sv
`timescale 1ns/1ps
// ==========
// Random and corner tests of the comparator control
// ==========
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic [1:0] clr = 2'h0;
  logic [7:0] p1 = 8'h00, n1 = 8'h00, p2 = 8'h00, n2 = 8'h00;
  logic [7:0] ca1, ca2;
  logic [1:0] raw, mir, flg, pin, gate, db, pwr, r;
  logic t1;
  dcc_pkg::dcc_cfg_t c1 = '0, c2 = '0;
  dcc_pkg::dcc_route_t pr1, nr1, pr2, nr2;
  int n_errors = 0;
  int n_compared = 0;
  dcc_far_model far1 (.ref_clk, .pos_level(p1), .neg_level(n1), .tmr_run(run),
    .raw_compare(raw[0]), .tmr1_clk_pre(t1));
  dcc_far_model far2 (.ref_clk, .pos_level(p2), .neg_level(n2), .tmr_run(run),
    .raw_compare(raw[1]), .tmr1_clk_pre());
  dcc_top uut (.ref_clk, .reset, .cfg_1(c1), .cfg_2(c2), .raw_compare_1(raw[0]),
    .raw_compare_2(raw[1]), .tmr1_clk_pre(t1), .flag_clear_1(clr[0]),
    .flag_clear_2(clr[1]), .comparator_control_a_1(ca1), .comparator_control_a_2(ca2),
    .shared_result_mirror(mir), .comparator_irq_flag(flg), .pin_result(pin),
    .timer_gate(gate), .pos_route_1(pr1), .neg_route_1(nr1), .pos_route_2(pr2),
    .neg_route_2(nr2), .deadband_on(db), .analog_power(pwr));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic res(dcc_pkg::dcc_cfg_t c, logic [7:0] p, logic [7:0] n);
    return c.output_invert ^ (c.comparator_on && p > n);
  endfunction
  function automatic logic [7:0] ctl(dcc_pkg::dcc_cfg_t c, logic o);
    return {c.comparator_on, o, 1'b0, c.output_invert, 2'h0, c.input_deadband_enable,
      c.sync_enable};
  endfunction
  function automatic logic [7:0] rt(logic on, logic [2:0] s, logic neg);
    logic [7:0] q;
    q = 8'h00;
    if (on && s < (neg ? 3'h4 : 3'h2)) q[3 + s] = 1'b1;
    if (on && s > (neg ? 3'h5 : 3'h4)) q[7 - s] = 1'b1;
    return q;
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic clear_flags();
    clr = 2'h3;
    wt(1);
    clr = 2'h0;
  endtask
  task automatic edge_run(logic [1:0] en, logic up);
    c1 = '0;
    c1.comparator_on = 1'b1;
    {c1.rise_edge_irq_enable, c1.fall_edge_irq_enable} = en;
    c2 = c1;
    {p1, n1} = up ? 16'h1020 : 16'h2010;
    {p2, n2} = {p1, n1};
    wt(8);
    clear_flags();
    wt(8);
    chk(8'(flg), 8'h00);
    {p1, n1} = up ? 16'h2010 : 16'h1020;
    {p2, n2} = {p1, n1};
    wt(8);
    chk(8'(flg), 8'({2{up ? en[1] : en[0]}}));
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(95));
    wt(12);
    reset = 1'b0;
    chk(ca1 | ca2, 8'h00);
    chk({mir, flg, pin, gate}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      c1 = 12'($urandom);
      c2 = 12'($urandom);
      c1.sync_enable = 1'b0;
      c2.sync_enable = 1'b0;
      c1.comparator_on = i < 24;
      c2.comparator_on = i > 7;
      c1.positive_channel_select = i[2:0];
      c2.positive_channel_select = i[2:0];
      c1.negative_channel_select = ~i[2:0];
      c2.negative_channel_select = ~i[2:0];
      {p1, n1, p2, n2} = $urandom;
      wt(8);
      r = {res(c2, p2, n2), res(c1, p1, n1)};
      chk(ca1, ctl(c1, r[0]));
      chk(ca2, ctl(c2, r[1]));
      chk({mir, pin, gate, pwr}, {r, r, r, c2.comparator_on, c1.comparator_on});
      chk(8'(db), 8'({c2.comparator_on & c2.input_deadband_enable,
        c1.comparator_on & c1.input_deadband_enable}));
      chk({1'b0, pr1}, rt(c1.comparator_on, i[2:0], 1'b0));
      chk({1'b0, nr1}, rt(c1.comparator_on, ~i[2:0], 1'b1));
      chk({1'b0, pr2}, rt(c2.comparator_on, i[2:0], 1'b0));
      chk({1'b0, nr2}, rt(c2.comparator_on, ~i[2:0], 1'b1));
    end
    $display("test random done");
    for (int k = 0; k < 8; k++) edge_run(k[2:1], k[0]);
    {p1, n1} = 16'h1020;
    wt(8);
    // edge meets clear
    // The rise reaches the detector three edges after the level change.
    {p1, n1} = 16'h2010;
    wt(3);
    clear_flags();
    wt(8);
    chk(8'(flg[0]), 8'h01);
    c1.comparator_on = 1'b0;
    wt(8);
    clear_flags();
    wt(8);
    c1.output_invert = 1'b1;
    wt(8);
    chk(8'(flg[0]), 8'h01);
    $display("test edges done");
    c1 = '0;
    c1.comparator_on = 1'b1;
    c1.sync_enable = 1'b1;
    run = 1'b1;
    wt(40);
    run = 1'b0;
    wt(12);
    {p1, n1} = 16'h1020;
    wt(12);
    chk(8'({ca1[6], pin[0], gate[0]}), 8'h03);
    run = 1'b1;
    wt(40);
    chk(8'({ca1[6], pin[0], gate[0]}), 8'h00);
    $display("test sync done");
    print_verdict();
  end
endmodule // tb_top
